// *** lba_accum.sv ***
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "lba_map.svh"

module lba_accum #(
    parameter int unsigned CYCLE_MS = `LBA_CYCLE_MS,
    parameter int unsigned CYCLE_CLKS = CYCLE_MS * `LBA_CLK_KHZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`LBA_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // activity monitor
    input wire logic activity_bad,
    // status
    output logic alarm,
    output logic [7:0] bucket_level
);

    localparam logic [`LBA_ADDR_W-1:0] ADDR_UPPER = `LBA_ADDR_W'({`LBA_IDX_UPPER, 2'b00});
    localparam logic [`LBA_ADDR_W-1:0] ADDR_LOWER = `LBA_ADDR_W'({`LBA_IDX_LOWER, 2'b00});
    localparam logic [`LBA_ADDR_W-1:0] ADDR_SIZE = `LBA_ADDR_W'({`LBA_IDX_SIZE, 2'b00});
    localparam logic [`LBA_ADDR_W-1:0] ADDR_DECAY = `LBA_ADDR_W'({`LBA_IDX_DECAY, 2'b00});
    localparam logic [`LBA_ADDR_W-1:0] ADDR_STATUS = `LBA_ADDR_W'({`LBA_IDX_STATUS, 2'b00});

    // cycle tick
    lba_tick_if tk_if ();

    lba_tick_gen #(
        .CYCLE_CLKS(CYCLE_CLKS)
    ) u_tick (
        .mclk(mclk),
        .rst_b(rst_b),
        .tk(tk_if.gen)
    );

    // ---------------- register file ----------------
    lba_pkg::lba_bus_st_t bus_q;
    lba_pkg::lba_bus_st_t bus_d;
    lba_pkg::lba_byte_t upper_q;
    lba_pkg::lba_byte_t upper_d;
    lba_pkg::lba_byte_t lower_q;
    lba_pkg::lba_byte_t lower_d;
    lba_pkg::lba_byte_t size_q;
    lba_pkg::lba_byte_t size_d;
    lba_pkg::lba_decay_t decay_q;
    lba_pkg::lba_decay_t decay_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] rdata;
    logic hit;
    logic commit;

    // state read back by software
    lba_pkg::lba_byte_t level_q;
    logic alarm_q;

    always_comb begin
        hit = 1'b1;
        rdata = '0;
        case (paddr)
            ADDR_UPPER: begin
                rdata = {24'h0, upper_q};
            end
            ADDR_LOWER: begin
                rdata = {24'h0, lower_q};
            end
            ADDR_SIZE: begin
                rdata = {24'h0, size_q};
            end
            ADDR_DECAY: begin
                rdata = {30'h0, decay_q};
            end
            ADDR_STATUS: begin
                rdata[`LBA_STAT_LEVEL_MSB:0] = level_q;
                rdata[`LBA_STAT_ALARM_BIT] = alarm_q;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // write lands on the edge where the master sees pready
    assign commit = (bus_q == lba_pkg::LBA_BUS_ANSWER) && psel && penable && pwrite && hit;

    always_comb begin
        bus_d = bus_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        upper_d = upper_q;
        lower_d = lower_q;
        size_d = size_q;
        decay_d = decay_q;
        case (bus_q)
            lba_pkg::LBA_BUS_IDLE: begin
                if (psel && penable) begin
                    bus_d = lba_pkg::LBA_BUS_ANSWER;
                    pready_d = 1'b1;
                    pslverr_d = !hit;
                    prdata_d = pwrite ? 32'h0 : rdata;
                end
            end
            lba_pkg::LBA_BUS_ANSWER: begin
                bus_d = lba_pkg::LBA_BUS_IDLE;
                if (commit) begin
                    case (paddr)
                        ADDR_UPPER: begin
                            upper_d = pwdata[7:0];
                        end
                        ADDR_LOWER: begin
                            lower_d = pwdata[7:0];
                        end
                        ADDR_SIZE: begin
                            size_d = pwdata[7:0];
                        end
                        ADDR_DECAY: begin
                            decay_d = pwdata[`LBA_DECAY_MSB:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                bus_d = lba_pkg::LBA_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus_q <= lba_pkg::LBA_BUS_IDLE;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            upper_q <= `LBA_RST_UPPER;
            lower_q <= `LBA_RST_LOWER;
            size_q <= `LBA_RST_SIZE;
            decay_q <= `LBA_RST_DECAY;
        end else begin
            bus_q <= bus_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            size_q <= size_d;
            decay_q <= decay_d;
        end
    end

    // ---------------- monitor input ----------------
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic bad_q;
    logic bad_d;
    logic seen_q;
    logic seen_d;
    logic cycle_bad;

    // pin input: accept a change once stages two and three agree
    always_comb begin
        sync_d = {sync_q[1:0], activity_bad};
        bad_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : bad_q;
    end

    // any bad report during the cycle marks it
    assign cycle_bad = seen_q | bad_q;

    always_comb begin
        if (tk_if.tick) begin
            seen_d = 1'b0;
        end else begin
            seen_d = cycle_bad;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= 3'h0;
            bad_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            bad_q <= bad_d;
            seen_q <= seen_d;
        end
    end

    // ---------------- bucket ----------------
    lba_pkg::lba_byte_t level_d;
    logic [3:0] stable_q;
    logic [3:0] stable_d;
    logic [3:0] period_last;
    logic alarm_d;

    // decay period of 1, 2, 4 or 8 cycles
    assign period_last = (4'h1 << decay_q) - 4'h1;

    always_comb begin
        level_d = level_q;
        stable_d = stable_q;
        if (tk_if.tick) begin
            if (cycle_bad) begin
                // a bad cycle breaks the stable run
                stable_d = 4'h0;
                if (level_q < size_q) begin
                    level_d = level_q + 8'h1;
                end else begin
                    level_d = size_q;
                end
            end else if (stable_q >= period_last) begin
                stable_d = 4'h0;
                if (level_q != 8'h0) begin
                    level_d = level_q - 8'h1;
                end
            end else begin
                stable_d = stable_q + 4'h1;
            end
        end
    end

    always_comb begin
        if (alarm_q) begin
            alarm_d = !(level_q < lower_q);
        end else begin
            alarm_d = (level_q >= upper_q);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= 8'h0;
            stable_q <= 4'h0;
            alarm_q <= 1'b0;
        end else begin
            level_q <= level_d;
            stable_q <= stable_d;
            alarm_q <= alarm_d;
        end
    end

    // outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign alarm = alarm_q;
    assign bucket_level = level_q;

endmodule

// *** lba_map.svh ***
`ifndef LBA_MAP_SVH
`define LBA_MAP_SVH

// register indices; byte address is four times the index
`define LBA_IDX_UPPER 8'h54
`define LBA_IDX_LOWER 8'h55
`define LBA_IDX_SIZE 8'h56
`define LBA_IDX_DECAY 8'h57
`define LBA_IDX_STATUS 8'h60
`define LBA_ADDR_W 12

// reset values
`define LBA_RST_UPPER 8'h06
`define LBA_RST_LOWER 8'h04
`define LBA_RST_SIZE 8'h08
`define LBA_RST_DECAY 2'h1

// field positions
`define LBA_DECAY_MSB 1
`define LBA_STAT_LEVEL_MSB 7
`define LBA_STAT_ALARM_BIT 8

// timing
`define LBA_CYCLE_MS 128
`define LBA_CLK_KHZ 125000

`endif

// *** lba_pkg.sv ***
package lba_pkg;

    typedef logic [7:0] lba_byte_t;
    typedef logic [1:0] lba_decay_t;

    typedef enum logic [0:0] {
        LBA_BUS_IDLE,
        LBA_BUS_ANSWER
    } lba_bus_st_t;

endpackage

// *** lba_tick_if.sv ***
`timescale 1ns/100ps

interface lba_tick_if;
    logic tick;

    modport gen (output tick);
    modport use_end (input tick);
endinterface

// *** lba_tick_gen.sv ***
`timescale 1ns/100ps

module lba_tick_gen #(
    parameter int unsigned CYCLE_CLKS = 16000000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // cycle tick
    lba_tick_if.gen tk
);

    localparam int CNT_W = (CYCLE_CLKS > 1) ? $clog2(CYCLE_CLKS) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLE_CLKS - 1);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        tick_d = (cnt_q == CNT_LAST);
        if (tick_d) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;

endmodule

// *** lba_accum_properties.sv ***
`timescale 1ns/100ps
module lba_accum_properties #(
    parameter int unsigned CYCLE_CLKS = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // status
    input wire logic alarm,
    input wire logic [7:0] bucket_level
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    ready_cause_a: assert property (!(psel && penable) |=> !pready) else $error("ready unasked");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data nonzero");
    level_step_a: assert property ($changed(bucket_level) |-> bucket_level - $past(bucket_level) == 8'h01
        || $past(bucket_level) - bucket_level == 8'h01) else $error("level jumped");
    level_cap_a: assert property (bucket_level <= 8'h08) else $error("level above size");
    alarm_set_a: assert property (bucket_level >= 8'h06 && !alarm |=> alarm) else $error("alarm late");
    alarm_cause_a: assert property ($rose(alarm) |-> bucket_level >= 8'h06) else $error("alarm early");
    alarm_keep_a: assert property (alarm && bucket_level >= 8'h04 |=> alarm) else $error("alarm dropped");
    alarm_clear_a: assert property (alarm && bucket_level < 8'h04 |=> !alarm) else $error("alarm stuck");
endmodule

bind lba_accum lba_accum_properties #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm(alarm),
    .bucket_level(bucket_level));

// *** lba_mon_model.sv ***
`timescale 1ns/100ps
module lba_mon_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // 0 stable, 1 failed, 2 erratic
    input wire logic [1:0] mode,
    // verdict
    output logic activity_bad
);
    logic [1:0] cnt_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    // erratic flips every two clocks so the filter sees it
    assign activity_bad = (mode == 2'h1) || (mode == 2'h2 && cnt_q[1]);
endmodule

// *** lba_accum_tb.sv ***
`timescale 1ns/100ps
module lba_accum_tb;
    localparam int CYC = 20;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, alarm, er, activity_bad;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] bucket_level;
    logic [1:0] mode;
    int fails, num_checks, cycles, n;
    lba_accum #(.CYCLE_CLKS(CYC)) u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .activity_bad(activity_bad), .alarm(alarm), .bucket_level(bucket_level));
    lba_mon_model u_mon (.mclk(mclk), .rst_b(rst_b), .mode(mode), .activity_bad(activity_bad));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_change(output int k);
        logic [7:0] v;
        v = bucket_level;
        k = 0;
        while (bucket_level === v && k < 2000) begin
            @(posedge mclk);
            k++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h150, 0); chk("upper", 32'h6, rd);
        apb(1'b0, 12'h154, 0); chk("lower", 32'h4, rd);
        apb(1'b0, 12'h158, 0); chk("size", 32'h8, rd);
        apb(1'b0, 12'h15c, 0); chk("decay", 32'h1, rd);
        apb(1'b0, 12'h180, 0); chk("status", 32'h0, rd);
        apb(1'b1, 12'h15c, 32'hff);
        apb(1'b0, 12'h15c, 0); chk("decay_high", 32'h3, rd);
        apb(1'b1, 12'h150, 32'h1a5);
        apb(1'b0, 12'h150, 0); chk("upper_wr", 32'ha5, rd);
        apb(1'b1, 12'h150, 32'h6);
        apb(1'b1, 12'h154, 32'h5a);
        apb(1'b0, 12'h154, 0); chk("lower_wr", 32'h5a, rd);
        apb(1'b1, 12'h154, 32'h4);
        apb(1'b1, 12'h158, 32'h3c);
        apb(1'b0, 12'h158, 0); chk("size_wr", 32'h3c, rd);
        apb(1'b1, 12'h158, 32'h8);
        apb(1'b1, 12'h180, 32'hff);
        apb(1'b0, 12'h180, 0); chk("status_ro", 32'h0, rd);
        apb(1'b0, 12'h004, 0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_fill();
        mode <= 2'h2;
        wait_change(n);
        wait_change(n); chk("fill_period", CYC, n);
        mode <= 2'h1;
        repeat (12 * CYC) @(posedge mclk);
        chk("level_sat", 32'h8, {24'h0, bucket_level});
        chk("alarm_set", 32'h1, {31'h0, alarm});
        apb(1'b0, 12'h180, 0); chk("status_full", 32'h108, rd);
        $display("test fill done");
    endtask
    task automatic t_decay();
        mode <= 2'h0;
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, 12'h15c, d);
            wait_change(n);
            wait_change(n); chk("decay_period", CYC << d, n);
        end
        apb(1'b1, 12'h15c, 0);
        repeat (3 * CYC) @(posedge mclk);
        chk("level_floor", 32'h0, {24'h0, bucket_level});
        chk("alarm_clear", 32'h0, {31'h0, alarm});
        $display("test decay done");
    endtask
    task automatic t_reset();
        mode <= 2'h1;
        wait_change(n);
        wait_change(n);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("rst_level", 32'h0, {24'h0, bucket_level});
        rst_b <= 1'b1;
        mode <= 2'h0;
        apb(1'b0, 12'h15c, 0); chk("rst_decay", 32'h1, rd);
        $display("test reset done");
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mode = 2'h0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_fill();
        t_decay();
        t_reset();
        close_out();
    end
endmodule
